/* File: include/ppd_pkg.sv */
// Purpose: shared constants for the programmable divider stabilizer core
// Assumes: one 25 MHz core clock, all divider inputs sampled as pulses
// Notes: digits are plain BCD, one nibble per stage
package ppd_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SYNC_DEPTH = 2;
   localparam int DIGIT_W = 4;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] LOW_BAND_MIN_DIGIT = 4'h5;
   localparam int DECADE_MOD = 10;
   localparam int DECADE_W = 4;
   localparam int FINAL_MOD = 35;
   localparam int FINAL_W = 6;
   localparam int REF_MOD = 1000;
   localparam int REF_W = 10;
endpackage : ppd_pkg

/* File: hdl/ppd_stage_counter.sv */
// Purpose: one divide-by-MOD stage with a programmable skip per overall cycle
// Assumes: in_pulse_in is a single-cycle pulse in the core clock domain
// Notes: out_pulse_out is combinational and lasts one cycle
module ppd_stage_counter #(
   parameter int unsigned MOD = 10,
   parameter int unsigned W = 4
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic sync_clear_in,
   input wire logic in_pulse_in,
   input wire logic restart_in,
   input wire logic [W-1:0] skip_in,
   output logic out_pulse_out
);
   localparam logic [W-1:0] TERMINAL = W'(MOD - 1);
   localparam logic [W-1:0] ZERO = '0;

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   wire logic at_terminal = (cnt_q == TERMINAL);
   // no terminal pulse leaks out while the chain is being cleared
   wire logic wrap = in_pulse_in && at_terminal && !sync_clear_in;
   wire logic [W-1:0] reload = restart_in ? skip_in : ZERO;

   assign out_pulse_out = wrap;

   always_comb begin
      cnt_d = cnt_q;
      if (sync_clear_in) begin
         cnt_d = ZERO;
      end else if (wrap) begin
         cnt_d = reload;
      end else if (in_pulse_in) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   AST_STAGE_OUT_NEEDS_IN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      out_pulse_out |-> in_pulse_in) else $error("stage output without input pulse");
   AST_STAGE_BOUND: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cnt_q <= TERMINAL) else $error("stage count beyond modulus");
   AST_STAGE_RELOAD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (wrap && restart_in && !sync_clear_in) |=> (cnt_q == $past(skip_in)))
      else $error("stage skip not loaded at cycle start");
   AST_STAGE_WRAP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (wrap && !restart_in && !sync_clear_in) |=> (cnt_q == ZERO))
      else $error("stage did not wrap to zero");
endmodule // ppd_stage_counter

/* File: hdl/ppd_divider_stabilizer.sv */
// Purpose: variable divider, reference divider and phase/frequency comparator
// Assumes: oscillator, standard and selection lines arrive asynchronously
// Notes: oscillator rate must stay well below half the core clock
//
// Summary of operation
// - divide oscillator by 25001 to 35000
// - three decades cascade into 26-to-35 stage
// - unprogrammed decade gives one pulse per ten
// - unprogrammed final stage divides by 35
// - digits set pulses skipped from count
// - low digit first decade, high digit final
// - skip applied once per overall divider cycle
// - final stage output is 100 pps locked
// - reference divides 100 kHz standard by 1000
// - comparator continuously compares both pulse trains
// - small error drives correction level toward lock
// - output spans 2.5001 to 3.5 MHz
// - top digit picks lower or upper oscillator
// - large error emits narrow sweep pulse
module ppd_divider_stabilizer (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic sync_clear_in,
   input wire logic osc_in,
   input wire logic std_100k_in,
   input wire logic [3:0] sel_digit0_in,
   input wire logic [3:0] sel_digit1_in,
   input wire logic [3:0] sel_digit2_in,
   input wire logic [3:0] sel_digit3_in,
   output logic pump_up_out,
   output logic pump_down_out,
   output logic sweep_up_out,
   output logic sweep_down_out,
   output logic var_pulse_out,
   output logic ref_pulse_out,
   output logic low_osc_en_out,
   output logic high_osc_en_out
);
   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [3:0] ppd_clamp_digit(input logic [3:0] d);
      ppd_clamp_digit = (d > ppd_pkg::DIGIT_MAX) ? ppd_pkg::DIGIT_MAX : d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronizers
   logic [2:0] osc_sync_q;
   logic [2:0] std_sync_q;
   logic [15:0] sel_meta_q;
   logic [15:0] sel_q;
   logic [15:0] sel_hold_q;
   logic [15:0] sel_raw;

   assign sel_raw = {sel_digit3_in, sel_digit2_in, sel_digit1_in, sel_digit0_in};

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_sync_q <= 3'h0;
         std_sync_q <= 3'h0;
         sel_meta_q <= 16'h0000;
         sel_q <= 16'h0000;
         sel_hold_q <= 16'h0000;
      end else begin
         osc_sync_q <= {osc_sync_q[1:0], osc_in};
         std_sync_q <= {std_sync_q[1:0], std_100k_in};
         sel_meta_q <= sel_raw;
         sel_q <= sel_meta_q;
         // digit word taken only once it stood two samples, no mixed codes
         if (sel_q == sel_meta_q) begin
            sel_hold_q <= sel_q;
         end
      end
   end

   wire logic osc_edge = osc_sync_q[1] && !osc_sync_q[2];
   wire logic std_edge = std_sync_q[1] && !std_sync_q[2];
   wire logic [3:0] digit0 =
      ppd_clamp_digit(sel_hold_q[0*ppd_pkg::DIGIT_W +: ppd_pkg::DIGIT_W]);
   wire logic [3:0] digit1 =
      ppd_clamp_digit(sel_hold_q[1*ppd_pkg::DIGIT_W +: ppd_pkg::DIGIT_W]);
   wire logic [3:0] digit2 =
      ppd_clamp_digit(sel_hold_q[2*ppd_pkg::DIGIT_W +: ppd_pkg::DIGIT_W]);
   wire logic [3:0] digit3 =
      ppd_clamp_digit(sel_hold_q[3*ppd_pkg::DIGIT_W +: ppd_pkg::DIGIT_W]);

   ////////////////////////////////////////////////////////////////////////////
   // variable divider chain
   logic dec1_pulse;
   logic dec2_pulse;
   logic dec3_pulse;
   logic final_pulse;

   // the final stage pulse marks the overall cycle boundary for every stage
   ppd_stage_counter #(.MOD(ppd_pkg::DECADE_MOD), .W(ppd_pkg::DECADE_W)) u_first_decade_stage (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sync_clear_in(sync_clear_in),
      .in_pulse_in(osc_edge),
      .restart_in(final_pulse),
      .skip_in(digit0),
      .out_pulse_out(dec1_pulse)
   );

   ppd_stage_counter #(.MOD(ppd_pkg::DECADE_MOD), .W(ppd_pkg::DECADE_W)) u_second_decade_stage (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sync_clear_in(sync_clear_in),
      .in_pulse_in(dec1_pulse),
      .restart_in(final_pulse),
      .skip_in(digit1),
      .out_pulse_out(dec2_pulse)
   );

   ppd_stage_counter #(.MOD(ppd_pkg::DECADE_MOD), .W(ppd_pkg::DECADE_W)) u_third_decade_stage (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sync_clear_in(sync_clear_in),
      .in_pulse_in(dec2_pulse),
      .restart_in(final_pulse),
      .skip_in(digit2),
      .out_pulse_out(dec3_pulse)
   );

   ppd_stage_counter #(.MOD(ppd_pkg::FINAL_MOD), .W(ppd_pkg::FINAL_W)) u_final_variable_stage (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sync_clear_in(sync_clear_in),
      .in_pulse_in(dec3_pulse),
      .restart_in(final_pulse),
      .skip_in({2'h0, digit3}),
      .out_pulse_out(final_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // reference divider
   logic ref_pulse;

   ppd_stage_counter #(.MOD(ppd_pkg::REF_MOD), .W(ppd_pkg::REF_W)) u_reference_divider (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .sync_clear_in(sync_clear_in),
      .in_pulse_in(std_edge),
      .restart_in(1'b0),
      .skip_in(10'h000),
      .out_pulse_out(ref_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // phase/frequency comparator
   logic up_q;
   logic down_q;
   logic ref_run_q;
   logic var_run_q;
   logic sweep_up_q;
   logic sweep_down_q;
   logic var_out_q;
   logic ref_out_q;
   logic low_osc_q;

   wire logic ref_only = ref_pulse && !final_pulse;
   wire logic var_only = final_pulse && !ref_pulse;
   wire logic up_raw = up_q || ref_pulse;
   wire logic down_raw = down_q || final_pulse;
   wire logic pump_cancel = up_raw && down_raw;
   wire logic up_d = sync_clear_in ? 1'b0 : (up_raw && !pump_cancel);
   wire logic down_d = sync_clear_in ? 1'b0 : (down_raw && !pump_cancel);
   wire logic ref_run_d = sync_clear_in ? 1'b0 :
                          (ref_only ? 1'b1 : ((final_pulse) ? 1'b0 : ref_run_q));
   wire logic var_run_d = sync_clear_in ? 1'b0 :
                          (var_only ? 1'b1 : ((ref_pulse) ? 1'b0 : var_run_q));
   wire logic sweep_up_d = !sync_clear_in && ref_only && ref_run_q;
   wire logic sweep_down_d = !sync_clear_in && var_only && var_run_q;
   wire logic low_osc_d = (digit3 >= ppd_pkg::LOW_BAND_MIN_DIGIT);

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         up_q <= 1'b0;
         down_q <= 1'b0;
         ref_run_q <= 1'b0;
         var_run_q <= 1'b0;
         sweep_up_q <= 1'b0;
         sweep_down_q <= 1'b0;
         var_out_q <= 1'b0;
         ref_out_q <= 1'b0;
         low_osc_q <= 1'b0;
      end else begin
         up_q <= up_d;
         down_q <= down_d;
         ref_run_q <= ref_run_d;
         var_run_q <= var_run_d;
         sweep_up_q <= sweep_up_d;
         sweep_down_q <= sweep_down_d;
         var_out_q <= final_pulse;
         ref_out_q <= ref_pulse;
         low_osc_q <= low_osc_d;
      end
   end

   assign pump_up_out = up_q;
   assign pump_down_out = down_q;
   assign sweep_up_out = sweep_up_q;
   assign sweep_down_out = sweep_down_q;
   assign var_pulse_out = var_out_q;
   assign ref_pulse_out = ref_out_q;
   assign low_osc_en_out = low_osc_q;
   assign high_osc_en_out = !low_osc_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_PFD_UP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (ref_only && !down_q && !sync_clear_in) |=> up_q)
      else $error("reference lead did not raise level");
   AST_PFD_DOWN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (var_only && !up_q && !sync_clear_in) |=> down_q)
      else $error("divider lead did not lower level");
   AST_PFD_EXCLUSIVE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !(up_q && down_q)) else $error("pump up and down both active");
   AST_SWEEP_DOWN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (var_only && var_run_q && !sync_clear_in) |=> (sweep_down_q ##1 !sweep_down_q))
      else $error("missing narrow sweep down pulse");
   AST_SWEEP_UP: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      sweep_up_q |-> ($past(ref_pulse) && !$past(final_pulse)))
      else $error("sweep up without reference pulse");
   AST_SYNC_CLEAR: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      sync_clear_in |=> (!up_q && !down_q && !ref_run_q && !var_run_q))
      else $error("comparator not cleared");
   AST_OSC_SELECT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (digit3 >= ppd_pkg::LOW_BAND_MIN_DIGIT) |=> (low_osc_en_out && !high_osc_en_out))
      else $error("lower oscillator not enabled");
   AST_VAR_OUT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      final_pulse |=> (var_pulse_out ##1 !var_pulse_out))
      else $error("variable output pulse wrong");
   AST_FINAL_NEEDS_CHAIN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      final_pulse |-> (dec3_pulse && dec2_pulse && dec1_pulse && osc_edge))
      else $error("final pulse without full chain");
endmodule // ppd_divider_stabilizer

/* File: tb/ppd_vco_model.sv */
// Purpose: oscillator model steered by the correction levels
// Assumes: one pulse-train edge every few core clocks, high and low >= 2 clocks
// Notes: counts its own rising edges for the bench
module ppd_vco_model (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic pump_up_in,
   input wire logic pump_down_in,
   output logic osc_out,
   output logic [31:0] edges_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   logic [3:0] half_w;
   // higher level, faster train
   assign half_w = pump_up_in ? 4'h2 : (pump_down_in ? 4'h4 : 4'h3);
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 4'h0;
         osc_out <= 1'b0;
         edges_out <= 32'h0;
      end else if (cnt_q + 4'h1 >= half_w) begin
         cnt_q <= 4'h0;
         osc_out <= !osc_out;
         edges_out <= edges_out + {31'h0, !osc_out};
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule // ppd_vco_model

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the divider stabilizer core
// Assumes: standard edges made by the bench, oscillator by the model
// Notes: full variable-divider cycles are too long for the run
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic sync_clear_in = 1'b0;
   logic std_100k_in = 1'b0;
   logic [3:0] sel_digit0_in = 4'h4;
   logic [3:0] sel_digit1_in = 4'h3;
   logic [3:0] sel_digit2_in = 4'h4;
   logic [3:0] sel_digit3_in = 4'h0;
   logic osc_w, pump_up_out, pump_down_out, sweep_up_out, sweep_down_out;
   logic var_pulse_out, ref_pulse_out, low_osc_en_out, high_osc_en_out;
   logic [31:0] osc_edges;
   int error_cnt = 0, compares = 0, cyc = 0;
   int ref_seen = 0, sup_seen = 0, sdn_seen = 0, var_seen = 0;
   int osc_cnt = 0, d1_cnt = 0, d2_cnt = 0, d3_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////
   ppd_divider_stabilizer dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .sync_clear_in(sync_clear_in), .osc_in(osc_w), .std_100k_in(std_100k_in),
      .sel_digit0_in(sel_digit0_in), .sel_digit1_in(sel_digit1_in),
      .sel_digit2_in(sel_digit2_in), .sel_digit3_in(sel_digit3_in),
      .pump_up_out(pump_up_out), .pump_down_out(pump_down_out),
      .sweep_up_out(sweep_up_out), .sweep_down_out(sweep_down_out),
      .var_pulse_out(var_pulse_out), .ref_pulse_out(ref_pulse_out),
      .low_osc_en_out(low_osc_en_out), .high_osc_en_out(high_osc_en_out));
   ppd_vco_model vco (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .pump_up_in(pump_up_out), .pump_down_in(pump_down_out), .osc_out(osc_w),
      .edges_out(osc_edges));
   initial forever #20 core_clk_in = ~core_clk_in;
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      cyc++;
      if (ref_pulse_out === 1'b1) ref_seen++;
      if (sweep_up_out === 1'b1) sup_seen++;
      if (sweep_down_out === 1'b1) sdn_seen++;
      if (var_pulse_out === 1'b1) var_seen++;
      if (dut.osc_edge === 1'b1) osc_cnt++;
      if (dut.dec1_pulse === 1'b1) d1_cnt++;
      if (dut.dec2_pulse === 1'b1) d2_cnt++;
      if (dut.dec3_pulse === 1'b1) d3_cnt++;
      if (cyc == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (exp !== got) begin
         error_cnt++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   task automatic std_edges(int n);
      repeat (n) begin
         std_100k_in <= 1'b1;
         tick(2);
         std_100k_in <= 1'b0;
         tick(2);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic scen_reset;
      check("pump_up", 0, pump_up_out);
      check("high_osc_en", 1, high_osc_en_out);
      check("low_osc_en", 0, low_osc_en_out);
   endtask
   task automatic scen_band;
      logic [3:0] v;
      for (int d = 0; d <= 10; d++) begin
         v = (d == 10) ? 4'hF : d[3:0];
         sel_digit3_in <= v;
         tick(6);
         check("low_osc_en", v >= 4'h5, low_osc_en_out);
         check("high_osc_en", v < 4'h5, high_osc_en_out);
      end
   endtask
   task automatic scen_ref;
      int r0, s0;
      r0 = ref_seen;
      s0 = sup_seen;
      std_edges(999);
      tick(8);
      check("ref_early", r0, ref_seen);
      std_edges(1);
      tick(8);
      check("ref_count", r0 + 1, ref_seen);
      check("pump_up", 1, pump_up_out);
      check("pump_down", 0, pump_down_out);
      std_edges(1000);
      tick(8);
      check("ref_count", r0 + 2, ref_seen);
      check("sweep_up", s0 + 1, sup_seen);
      check("sweep_down", 0, sdn_seen);
   endtask
   task automatic scen_chain;
      check("decade1", osc_cnt / ppd_pkg::DECADE_MOD, d1_cnt);
      check("decade2", d1_cnt / ppd_pkg::DECADE_MOD, d2_cnt);
      check("decade3", d2_cnt / ppd_pkg::DECADE_MOD, d3_cnt);
      check("chain_moving", 1, d3_cnt > 0);
   endtask
   task automatic scen_clear;
      int r0, s0;
      std_edges(500);
      sync_clear_in <= 1'b1;
      tick(1);
      sync_clear_in <= 1'b0;
      tick(2);
      check("pump_up", 0, pump_up_out);
      r0 = ref_seen;
      s0 = sup_seen;
      std_edges(999);
      tick(8);
      check("ref_early", r0, ref_seen);
      std_edges(1);
      tick(8);
      check("ref_count", r0 + 1, ref_seen);
      check("sweep_up", s0, sup_seen);
      check("pump_up", 1, pump_up_out);
   endtask
   task automatic scen_var;
      check("var_pulse", 0, var_seen);
      check("osc_running", 1, osc_edges > 32'd1000);
   endtask
   initial begin
      tick(3);
      scen_reset();
      tick(5);
      rst_n_in <= 1'b1;
      tick(4);
      scen_band();
      scen_ref();
      scen_chain();
      scen_clear();
      scen_var();
      give_verdict();
   end
endmodule // testbench
